// [include/pbio_pkg.sv]
// package of constants for the port b pin multiplexer
package pbio_pkg;
   localparam int PBIO_PINS = 8;
   localparam int PBIO_TMR_PINS = 4;
   localparam int PBIO_ADDR_W = 24;
   localparam int PBIO_DATA_W = 32;
   // printed offsets are word indexes; byte address is four times the index
   localparam logic [PBIO_ADDR_W-1:0] PBIO_DIR_INDEX = 24'h0EE00A;
   localparam logic [PBIO_ADDR_W-1:0] PBIO_ODR_INDEX = 24'h0FFFDA;
   localparam logic [PBIO_ADDR_W-1:0] PBIO_DIR_ADDR = 24'h3B8028;
   localparam logic [PBIO_ADDR_W-1:0] PBIO_ODR_ADDR = 24'h3FFF68;
   localparam logic [PBIO_PINS-1:0] PBIO_DIR_RESET = 8'h00;
   localparam logic [PBIO_PINS-1:0] PBIO_ODR_RESET = 8'h00;
   localparam logic [PBIO_PINS-1:0] PBIO_DIR_READ = 8'hFF;
   // pins of the lower nibble that can feed a timer input
   localparam logic [PBIO_TMR_PINS-1:0] PBIO_TMR_IN_MASK = 4'hA;
   localparam logic [2:0] PBIO_MODE_CS_LO = 3'h1;
   localparam logic [2:0] PBIO_MODE_CS_HI = 3'h5;
endpackage

// [tb/pbio_board.sv]
// board model: external circuitry that sits on the port pins
`timescale 1ns/1ps
`default_nettype none
module pbio_board
   import pbio_pkg::*;
(
   input wire logic [PBIO_PINS-1:0] board_level,
   input wire logic [PBIO_PINS-1:0] pin_out,
   input wire logic [PBIO_PINS-1:0] pin_oe,
   output logic [PBIO_PINS-1:0] pin_in
);
   // a driven pin reads back its drive, an undriven one shows the board level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule
`default_nettype wire

// [tb/pbio_port_tb.sv]
// testbench of the port b pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module pbio_port_tb
   import pbio_pkg::*;
;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, hw_standby, err;
   logic [23:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] op_mode;
   logic [7:0] pen, pat, pin_in, pin_out, pin_oe, board;
   logic [3:0] tsel, tout, cap, cse, csn, timer_in;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   pbio_port i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .hw_standby(hw_standby), .op_mode(op_mode),
      .pattern_enable_reg_hi(pen), .pattern_out(pat), .timer_output_sel_nz(tsel),
      .timer_out(tout), .capture_input_enable(cap), .chipsel_enable(cse),
      .chipsel_n(csn), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .timer_in(timer_in));
   pbio_board i_board (.board_level(board), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));
   initial
   begin
      clock = 0;
      forever #12.5 clock = ~clock;
   end
   task stop_test;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         $display("mismatch at %0t: run timed out", $time);
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [23:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clock);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle;
      repeat (6) @(posedge clock);
   endtask
   initial
   begin
      {psel, penable, pwrite, hw_standby, paddr, pwdata} = '0;
      {pen, pat, tsel, tout, cap, cse, csn} = '0;
      op_mode = 3'h1;
      board = 8'h3C;
      rst = 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, PBIO_DIR_ADDR, 32'h0);
      chk(rd, 32'h000000FF);
      apb(1'b0, PBIO_ODR_ADDR, 32'h0);
      chk(rd, {24'h0, board});
      chk({31'h0, err}, 32'h0);
      chk({24'h0, pin_oe}, 32'h0);
      $display("test reset done");
      apb(1'b1, PBIO_DIR_ADDR, 32'hFFFFFFF0);
      apb(1'b1, PBIO_ODR_ADDR, 32'h000000A5);
      settle();
      chk({24'h0, pin_oe}, 32'h000000F0);
      chk({24'h0, pin_out & 8'hF0}, 32'h000000A0);
      apb(1'b0, PBIO_ODR_ADDR, 32'h0);
      chk(rd, 32'h000000AC);
      apb(1'b0, PBIO_DIR_ADDR, 32'h0);
      chk(rd, 32'h000000FF);
      $display("test general io done");
      // software sets direction as well as pattern enable
      pen <= 8'hF0;
      pat <= 8'h50;
      settle();
      chk({28'h0, pin_out[7:4]}, 32'h5);
      apb(1'b1, PBIO_DIR_ADDR, 32'h000000FF);
      cse <= 4'hF;
      csn <= 4'h5;
      settle();
      chk({24'h0, pin_oe}, 32'h000000FF);
      chk({28'h0, pin_out[3:0]}, 32'h5);
      tsel <= 4'h9;
      tout <= 4'h6;
      settle();
      chk({28'h0, pin_out[3:0]}, 32'h4);
      op_mode <= 3'h7;
      tsel <= 4'h0;
      apb(1'b1, PBIO_DIR_ADDR, 32'h000000F0);
      settle();
      chk({24'h0, pin_oe}, 32'h000000F0);
      $display("test pin functions done");
      cap <= 4'hF;
      board <= 8'h0A;
      settle();
      chk({28'h0, timer_in}, 32'hA);
      apb(1'b1, 24'h000010, 32'h00000055);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, PBIO_ODR_ADDR, 32'h0);
      chk(rd, 32'h000000AA);
      hw_standby <= 1'b1;
      settle();
      chk({24'h0, pin_oe}, 32'h0);
      hw_standby <= 1'b0;
      apb(1'b0, PBIO_ODR_ADDR, 32'h0);
      chk(rd, {24'h0, board});
      apb(1'b1, PBIO_DIR_ADDR, 32'h000000FF);
      apb(1'b0, PBIO_ODR_ADDR, 32'h0);
      chk(rd, 32'h00000000);
      apb(1'b1, PBIO_DIR_ADDR, 32'h00000000);
      op_mode <= 3'h5;
      settle();
      chk({24'h0, pin_oe}, 32'h0000000F);
      chk({28'h0, pin_out[3:0]}, 32'h5);
      op_mode <= 3'h6;
      settle();
      chk({24'h0, pin_oe}, 32'h00000000);
      $display("test capture and standby done");
      stop_test();
   end
endmodule
`default_nettype wire

// [verilog/pbio_port.sv]
// port b eight-bit i/o port with pin function multiplexer and apb registers
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - eight pins, each shares alternate functions
// - reset or hardware standby gives plain i/o
// - direction bit 1 drives, 0 inputs
// - direction register write-only, reads all ones
// - direction cleared by reset, hardware standby
// - direction kept in software standby
// - output data rw, cleared, kept likewise
// - general output drives output data bit
// - read gives data if output, else pin
// - pins 7-4 input, general or pattern
// - nonzero timer select overrides pin 3
// - pin 3 chip select 4, else general
// - pin 3 input feeds timer capture
// - selection scheme depends on operating mode
// - modes 6,7 have no chip selects
// - pins 2-0 timer, chip select, general
module pbio_port
   import pbio_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PBIO_ADDR_W-1:0] paddr,
   input wire logic [PBIO_DATA_W-1:0] pwdata,
   output logic pready,
   output logic [PBIO_DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic hw_standby,
   input wire logic [2:0] op_mode,
   input wire logic [PBIO_PINS-1:0] pattern_enable_reg_hi,
   input wire logic [PBIO_PINS-1:0] pattern_out,
   input wire logic [PBIO_TMR_PINS-1:0] timer_output_sel_nz,
   input wire logic [PBIO_TMR_PINS-1:0] timer_out,
   input wire logic [PBIO_TMR_PINS-1:0] capture_input_enable,
   input wire logic [PBIO_TMR_PINS-1:0] chipsel_enable,
   input wire logic [PBIO_TMR_PINS-1:0] chipsel_n,
   input wire logic [PBIO_PINS-1:0] pin_in,
   output logic [PBIO_PINS-1:0] pin_out,
   output logic [PBIO_PINS-1:0] pin_oe,
   output logic [PBIO_TMR_PINS-1:0] timer_in
);

   typedef struct packed {
      logic [PBIO_PINS-1:0] dir;
      logic [PBIO_PINS-1:0] odr;
      logic [PBIO_PINS-1:0] pin_s1;
      logic [PBIO_PINS-1:0] pin_s2;
      logic [2:0] mode_s1;
      logic [2:0] mode_s2;
      logic pready;
      logic pslverr;
      logic [PBIO_DATA_W-1:0] prdata;
      logic [PBIO_PINS-1:0] pin_out;
      logic [PBIO_PINS-1:0] pin_oe;
      logic [PBIO_TMR_PINS-1:0] timer_in;
   } pbio_state_t;

   pbio_state_t st_r;
   pbio_state_t st_nxt;
   logic mode_cs;
   logic hit_dir;
   logic hit_odr;
   logic [PBIO_PINS-1:0] rd_port;
   logic [PBIO_PINS-1:0] tsel_w;
   logic [PBIO_PINS-1:0] tout_w;
   logic [PBIO_PINS-1:0] cse_w;
   logic [PBIO_PINS-1:0] csn_w;

   // widths the logic cannot serve are refused at elaboration
   if (PBIO_TMR_PINS > PBIO_PINS || PBIO_DATA_W < PBIO_PINS)
   begin : g_bad_cfg
      $error("pbio_port: unsupported package widths");
   end

   // timer and chip-select inputs exist only for the low pins; upper pins see zero
   assign tsel_w = {{(PBIO_PINS-PBIO_TMR_PINS){1'b0}}, timer_output_sel_nz};
   assign tout_w = {{(PBIO_PINS-PBIO_TMR_PINS){1'b0}}, timer_out};
   assign cse_w = {{(PBIO_PINS-PBIO_TMR_PINS){1'b0}}, chipsel_enable};
   assign csn_w = {{(PBIO_PINS-PBIO_TMR_PINS){1'b0}}, chipsel_n};

   // port and mode pins come from outside, so only the second stage is read
   assign mode_cs = (st_r.mode_s2 >= PBIO_MODE_CS_LO) && (st_r.mode_s2 <= PBIO_MODE_CS_HI);
   assign hit_dir = (paddr == PBIO_DIR_ADDR);
   assign hit_odr = (paddr == PBIO_ODR_ADDR);

   always_comb
   begin
      for (int i = 0; i < PBIO_PINS; i++)
      begin
         rd_port[i] = st_r.dir[i] ? st_r.odr[i] : st_r.pin_s2[i];
      end
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pin_s1 = pin_in;
      st_nxt.pin_s2 = st_r.pin_s1;
      st_nxt.mode_s1 = op_mode;
      st_nxt.mode_s2 = st_r.mode_s1;
      // one wait state: answer in the second access cycle
      st_nxt.pready = psel && penable && !st_r.pready;
      st_nxt.pslverr = psel && penable && !st_r.pready && !hit_dir && !hit_odr;
      if (psel && penable && !st_r.pready && !pwrite)
      begin
         if (hit_dir)
         begin
            st_nxt.prdata = {{(PBIO_DATA_W-PBIO_PINS){1'b0}}, PBIO_DIR_READ};
         end
         else if (hit_odr)
         begin
            st_nxt.prdata = {{(PBIO_DATA_W-PBIO_PINS){1'b0}}, rd_port};
         end
         else
         begin
            st_nxt.prdata = '0;
         end
      end
      if (psel && penable && st_r.pready && pwrite)
      begin
         if (hit_dir)
         begin
            st_nxt.dir = pwdata[PBIO_PINS-1:0];
         end
         if (hit_odr)
         begin
            st_nxt.odr = pwdata[PBIO_PINS-1:0];
         end
      end
      // software standby has no effect here, so both registers simply hold
      if (hw_standby)
      begin
         st_nxt.dir = PBIO_DIR_RESET;
         st_nxt.odr = PBIO_ODR_RESET;
      end
      // pin function multiplexer
      for (int i = 0; i < PBIO_PINS; i++)
      begin
         st_nxt.pin_out[i] = 1'b0;
         st_nxt.pin_oe[i] = 1'b0;
         if (tsel_w[i])
         begin
            st_nxt.pin_out[i] = tout_w[i];
            st_nxt.pin_oe[i] = 1'b1;
         end
         else if (mode_cs && cse_w[i])
         begin
            st_nxt.pin_out[i] = csn_w[i];
            st_nxt.pin_oe[i] = 1'b1;
         end
         else if (st_r.dir[i])
         begin
            // pattern output needs both the direction and pattern-enable bits
            st_nxt.pin_out[i] = pattern_enable_reg_hi[i] ? pattern_out[i] : st_r.odr[i];
            st_nxt.pin_oe[i] = 1'b1;
         end
         if (hw_standby)
         begin
            st_nxt.pin_oe[i] = 1'b0;
         end
      end
      for (int i = 0; i < PBIO_TMR_PINS; i++)
      begin
         st_nxt.timer_in[i] = PBIO_TMR_IN_MASK[i] && capture_input_enable[i]
            && !st_nxt.pin_oe[i] && st_r.pin_s2[i];
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign prdata = st_r.prdata;
   assign pin_out = st_r.pin_out;
   assign pin_oe = st_r.pin_oe;
   assign timer_in = st_r.timer_in;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   property p_dir_reads_ones;
      (psel && penable && !pready && !pwrite && hit_dir) |=> (pready && prdata == 32'h000000FF);
   endproperty
   a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("dir read not all ones");

   property p_standby_clears;
      hw_standby |=> (st_r.dir == 8'h00 && st_r.odr == 8'h00 && pin_oe == 8'h00);
   endproperty
   a_standby_clears: assert property (p_standby_clears) else $error("standby did not clear");

   property p_dir_holds;
      !(psel && penable && pready && pwrite) && !hw_standby |=> $stable(st_r.dir);
   endproperty
   a_dir_holds: assert property (p_dir_holds) else $error("direction changed without write");

   property p_general_out;
      (!hw_standby && st_r.dir[7] && !pattern_enable_reg_hi[7])
         |=> (pin_oe[7] && pin_out[7] == $past(st_r.odr[7]));
   endproperty
   a_general_out: assert property (p_general_out) else $error("general output wrong");

   property p_pattern_out;
      (!hw_standby && st_r.dir[5] && pattern_enable_reg_hi[5])
         |=> (pin_oe[5] && pin_out[5] == $past(pattern_out[5]));
   endproperty
   a_pattern_out: assert property (p_pattern_out) else $error("pattern output wrong");

   property p_input_released;
      (!st_r.dir[6]) |=> !pin_oe[6];
   endproperty
   a_input_released: assert property (p_input_released) else $error("input pin driven");

   property p_timer_wins;
      (!hw_standby && timer_output_sel_nz[3]) |=> (pin_oe[3] && pin_out[3] == $past(timer_out[3]));
   endproperty
   a_timer_wins: assert property (p_timer_wins) else $error("timer did not win pin 3");

   property p_cs4;
      (!hw_standby && !timer_output_sel_nz[3] && mode_cs && chipsel_enable[3])
         |=> (pin_oe[3] && pin_out[3] == $past(chipsel_n[3]));
   endproperty
   a_cs4: assert property (p_cs4) else $error("chip select 4 not on pin 3");

   property p_no_cs_high_modes;
      (!hw_standby && !mode_cs && !timer_output_sel_nz[0] && !st_r.dir[0]) |=> !pin_oe[0];
   endproperty
   a_no_cs_high_modes: assert property (p_no_cs_high_modes) else $error("chip select in mode 6/7");

   property p_cs_low_pins;
      (!hw_standby && !timer_output_sel_nz[1] && mode_cs && chipsel_enable[1])
         |=> (pin_oe[1] && pin_out[1] == $past(chipsel_n[1]));
   endproperty
   a_cs_low_pins: assert property (p_cs_low_pins) else $error("chip select on pin 1 missing");

   property p_capture;
      (!hw_standby && capture_input_enable[3] && !timer_output_sel_nz[3]
         && !(mode_cs && chipsel_enable[3]) && !st_r.dir[3])
         |=> (timer_in[3] == $past(st_r.pin_s2[3]));
   endproperty
   a_capture: assert property (p_capture) else $error("capture input not routed");

   property p_read_port;
      (psel && penable && !pready && !pwrite && hit_odr)
         |=> (prdata[7:0] == $past(rd_port) && !pslverr);
   endproperty
   a_read_port: assert property (p_read_port) else $error("port read wrong");

   property p_odr_holds;
      !(psel && penable && pready && pwrite) && !hw_standby |=> $stable(st_r.odr);
   endproperty
   a_odr_holds: assert property (p_odr_holds) else $error("data changed without write");

   property p_dir_write;
      (psel && penable && pready && pwrite && hit_dir && !hw_standby)
         |=> (st_r.dir == $past(pwdata[7:0]));
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   property p_oe_only_output;
      (!hw_standby && !st_r.dir[2] && !tsel_w[2] && !(mode_cs && cse_w[2])) |=> !pin_oe[2];
   endproperty
   a_oe_only_output: assert property (p_oe_only_output) else $error("driver on for input");

   property p_no_capture_pins;
      1'b1 |-> (timer_in[2] == 1'b0 && timer_in[0] == 1'b0);
   endproperty
   a_no_capture_pins: assert property (p_no_capture_pins) else $error("capture on output pin");

   property p_one_wait;
      (psel && penable && !pready) |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus answer late");

   property p_mode_hi_pin3;
      (!hw_standby && !mode_cs && !tsel_w[3] && !st_r.dir[3]) |=> !pin_oe[3];
   endproperty
   a_mode_hi_pin3: assert property (p_mode_hi_pin3) else $error("pin 3 driven in mode 6/7");

   property p_timer_pin0;
      (!hw_standby && tsel_w[0]) |=> (pin_oe[0] && pin_out[0] == $past(tout_w[0]));
   endproperty
   a_timer_pin0: assert property (p_timer_pin0) else $error("timer did not win pin 0");

   property p_timer_over_cs;
      (!hw_standby && tsel_w[2] && mode_cs && cse_w[2]) |=> (pin_out[2] == $past(tout_w[2]));
   endproperty
   a_timer_over_cs: assert property (p_timer_over_cs) else $error("chip select beat timer");

   property p_pattern_pin3;
      (!hw_standby && !tsel_w[3] && !(mode_cs && cse_w[3]) && st_r.dir[3]
         && pattern_enable_reg_hi[3])
         |=> (pin_oe[3] && pin_out[3] == $past(pattern_out[3]));
   endproperty
   a_pattern_pin3: assert property (p_pattern_pin3) else $error("pin 3 pattern wrong");

   property p_standby_oe;
      hw_standby |=> (pin_oe == 8'h00);
   endproperty
   a_standby_oe: assert property (p_standby_oe) else $error("pin driven in standby");

   c_write_dir: cover property (psel && penable && pready && pwrite && hit_dir);
   c_cs4_out: cover property (pin_oe[3] && mode_cs && chipsel_enable[3]);
   c_pattern: cover property (pin_oe[4] && pattern_enable_reg_hi[4]);
   c_bad_addr: cover property (pready && pslverr);
   c_timer_in: cover property (timer_in[3]);

endmodule
`default_nettype wire
